// File: shared/lmsc_cfg.svh
// constants for the link maintenance state controller
`ifndef LMSC_CFG_SVH
`define LMSC_CFG_SVH
// ==========================================================
// terminal state codes
`define LMSC_CODE_ACT   6'h20
`define LMSC_CODE_AFLT  6'h21
`define LMSC_CODE_AREM  6'h22
`define LMSC_CODE_APWR  6'h23
`define LMSC_CODE_ATRB  6'h24
`define LMSC_CODE_MFLT  6'h25
`define LMSC_CODE_MREM  6'h26
`define LMSC_CODE_POFF  6'h27
`define LMSC_CODE_FORC  6'h28
// ==========================================================
// timing
`define LMSC_CLK_HZ     10000000
`define LMSC_NORM_MON_S 18
`define LMSC_EMER_MON_S 3
`define LMSC_BAD_MIN    3
`define LMSC_SEC_PER_MIN 60
`define LMSC_CNT_W      32
`define LMSC_CNT_ONE    32'h0000_0001
`define LMSC_CNT_ZERO   32'h0000_0000
// ==========================================================
// link indices and report kinds
`define LMSC_LINK_A     1'b0
`define LMSC_LINK_B     1'b1
`define LMSC_RPT_TERM   1'b0
`define LMSC_RPT_LINK   1'b1
`endif

// File: shared/lmsc_pkg.sv
// types for the link maintenance state controller
package lmsc_pkg;
  // link maintenance states
  typedef enum logic [2:0] {
    LINK_ACTIVE,
    LINK_STANDBY_CONNECTED,
    LINK_STANDBY_DELAYED,
    LINK_UNAVAILABLE_RELEASED,
    LINK_UNAVAILABLE_OPERATED
  } lmsc_link_t;
  // terminal maintenance states
  typedef enum logic [3:0] {
    T_ACTIVE, T_AUTO_FAULT, T_AUTO_REMOVE, T_AUTO_POWER_ALARM,
    T_AUTO_TROUBLE_ANALYSIS, T_MANUAL_FAULT, T_MANUAL_REMOVE,
    T_POWER_OFF, T_FORCED
  } lmsc_term_t;
  // standby loop test sequencer
  typedef enum logic [1:0] {
    LT_IDLE, LT_LOOP, LT_SEND, LT_WAIT
  } lmsc_loop_t;
endpackage

// File: src/lmsc_link.sv
// state machine for one voice-frequency link
`timescale 1ns/1ns
`default_nettype none
module lmsc_link (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               cmd_release,
  input  wire logic               cmd_operate,
  input  wire logic               cmd_ready,
  input  wire logic               cmd_delay,
  input  wire logic               cmd_activate,
  input  wire logic               mate_active,
  output lmsc_pkg::lmsc_link_t    state_r,
  output logic                    connected_r,
  output logic                    traffic_r,
  output logic                    access_op_r
);
  import lmsc_pkg::*;
  lmsc_link_t st_nxt;

  // ========================================================
  // next state; illegal requests keep the state
  always_comb begin
    st_nxt = state_r;
    if (cmd_release) begin
      st_nxt = LINK_UNAVAILABLE_RELEASED;
    end else if (cmd_operate) begin
      st_nxt = LINK_UNAVAILABLE_OPERATED;
    end else if (cmd_activate) begin
      // only from standby-connected, and never beside an active mate
      if (state_r == LINK_STANDBY_CONNECTED && !mate_active) begin
        st_nxt = LINK_ACTIVE;
      end
    end else if (cmd_ready) begin
      st_nxt = LINK_STANDBY_CONNECTED;
    end else if (cmd_delay) begin
      if (state_r == LINK_ACTIVE || state_r == LINK_STANDBY_CONNECTED) begin
        st_nxt = LINK_STANDBY_DELAYED;
      end
    end
  end

  // ========================================================
  // state and decoded outputs, all registered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r     <= LINK_STANDBY_CONNECTED;
      connected_r <= 1'b1;
      traffic_r   <= 1'b0;
      access_op_r <= 1'b0;
    end else begin
      state_r     <= st_nxt;
      connected_r <= (st_nxt == LINK_ACTIVE) ||
                     (st_nxt == LINK_STANDBY_CONNECTED);
      traffic_r   <= (st_nxt == LINK_ACTIVE);
      access_op_r <= (st_nxt == LINK_UNAVAILABLE_OPERATED);
    end
  end

  // ========================================================
  // checks
  a_delay_detached: assert property (@(posedge core_clk) disable iff (rst)
    state_r == LINK_STANDBY_DELAYED |-> !connected_r && !traffic_r)
    else $error("delayed link attached or carrying traffic");
  a_active_path: assert property (@(posedge core_clk) disable iff (rst)
    state_r == LINK_ACTIVE && $past(state_r) != LINK_ACTIVE
    |-> $past(state_r) == LINK_STANDBY_CONNECTED)
    else $error("link became active without standby-connected");
endmodule
`default_nettype wire

// File: src/lmsc_ctrl.sv
// terminal and link maintenance state controller, top level
// Notes on behaviour
// - terminal sits in one of nine states, coded 32 to 40.
// - automatic removal followed by failed or aborted diagnostic gives auto fault.
// - in auto fault, manual diagnostic pass goes to auto remove, else stays.
// - single or double link failure moves active terminal to auto remove.
// - restoral from any manual state passes through auto remove first.
// - fuse alarm from active, auto fault, auto remove or trouble analysis enters power alarm and reports.
// - automatic diagnostic request enters trouble analysis; pass remove, fail fault.
// - manual fault reached from active only via manual remove; stays eligible.
// - manual remove entered from active on request; operates, stays eligible.
// - power off is ineligible and may move to any other manual state.
// - forced unavailable is powered, idle, ineligible, never made active automatically.
// - status query returns current terminal state code as a status report.
// - at most one of the two links is in service.
// - standby-connected link is attached, idle, and may go straight active.
// - a link must pass standby-connected before becoming active.
// - standby-delayed link neither carries traffic nor is attached.
// - release command marks link unavailable and releases its access circuit.
// - operate command marks link unavailable and operates its access circuit.
// - far-end test request: loop standby link, answer, then take result.
// - office-started test applies the loop before signalling the far end.
// - a loop-around path exists at this end for far-end testing.
// - normal recovery monitors quality 18 seconds in auto remove.
// - emergency recovery after double failure monitors only 3 seconds.
// - unacceptable quality for 3 minutes in auto remove starts trouble analysis.
`timescale 1ns/1ns
`default_nettype none
`include "lmsc_cfg.svh"
module lmsc_ctrl #(
  parameter int unsigned NORM_MON_CYC = `LMSC_NORM_MON_S * `LMSC_CLK_HZ,
  parameter int unsigned EMER_MON_CYC = `LMSC_EMER_MON_S * `LMSC_CLK_HZ,
  parameter int unsigned BAD_LIM_CYC  =
    `LMSC_BAD_MIN * `LMSC_SEC_PER_MIN * `LMSC_CLK_HZ
) (
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            link_fail_single,
  input  wire logic            link_fail_double,
  input  wire logic            fuse_alarm,
  input  wire logic            quality_ok,
  input  wire logic            auto_diag_req,
  input  wire logic            manual_diag_req,
  input  wire logic            diag_done,
  input  wire logic            diag_pass,
  input  wire logic            req_remove,
  input  wire logic            req_manual_fault,
  input  wire logic            req_power_off,
  input  wire logic            req_forced,
  input  wire logic            req_restore,
  input  wire logic            terminal_status_query,
  input  wire logic            link_status_query,
  input  wire logic            link_sel,
  input  wire logic            link_release_cmd,
  input  wire logic            link_operate_cmd,
  input  wire logic            link_ready_cmd,
  input  wire logic            link_delay_cmd,
  input  wire logic            link_activate_cmd,
  input  wire logic            tp_test_standby_in,
  input  wire logic            tp_test_passed,
  input  wire logic            tp_test_failed,
  input  wire logic            office_test_req,
  output logic [5:0]           term_code_r,
  output logic                 term_operating_r,
  output logic                 term_eligible_r,
  output logic                 term_powered_r,
  output logic                 diag_start_r,
  output logic                 status_report_r,
  output logic                 status_kind_r,
  output logic [5:0]           status_code_r,
  output lmsc_pkg::lmsc_link_t voice_link_a_r,
  output lmsc_pkg::lmsc_link_t voice_link_b_r,
  output logic [1:0]           link_connected_r,
  output logic [1:0]           link_traffic_r,
  output logic [1:0]           access_operated_r,
  output logic [1:0]           loop_applied_r,
  output logic                 tp_test_standby_out_r,
  output logic                 test_result_r,
  output logic                 test_passed_r
);
  import lmsc_pkg::*;

  lmsc_term_t              st_r;
  lmsc_term_t              st_nxt;
  logic                    emer_r;
  logic                    man_diag_r;
  logic [`LMSC_CNT_W-1:0]  good_cnt_r;
  logic [`LMSC_CNT_W-1:0]  bad_cnt_r;
  logic                    good_done;
  logic                    bad_done;
  logic                    auto_st;
  logic                    manual_st;
  logic                    pwr_evt;
  lmsc_link_t              lst   [2];
  logic [1:0]              lconn;
  logic [1:0]              ltraf;
  logic [1:0]              lop;
  lmsc_loop_t              lt_r;
  logic                    sb_r;

  // ==========================================================
  // state code lookup
  function automatic logic [5:0] code_of(input lmsc_term_t s);
    case (s)
      T_ACTIVE:                code_of = `LMSC_CODE_ACT;
      T_AUTO_FAULT:            code_of = `LMSC_CODE_AFLT;
      T_AUTO_REMOVE:           code_of = `LMSC_CODE_AREM;
      T_AUTO_POWER_ALARM:      code_of = `LMSC_CODE_APWR;
      T_AUTO_TROUBLE_ANALYSIS: code_of = `LMSC_CODE_ATRB;
      T_MANUAL_FAULT:          code_of = `LMSC_CODE_MFLT;
      T_MANUAL_REMOVE:         code_of = `LMSC_CODE_MREM;
      T_POWER_OFF:             code_of = `LMSC_CODE_POFF;
      default:                 code_of = `LMSC_CODE_FORC;
    endcase
  endfunction

  // ==========================================================
  // recovery monitor: quality timers in auto remove
  // emergency entry shortens the clean-quality window
  assign good_done = emer_r ? (good_cnt_r >= `LMSC_CNT_W'(EMER_MON_CYC - 1))
                            : (good_cnt_r >= `LMSC_CNT_W'(NORM_MON_CYC - 1));
  assign bad_done  = bad_cnt_r >= `LMSC_CNT_W'(BAD_LIM_CYC - 1);

  // clean-quality counter, restarts on any bad sample
  always_ff @(posedge core_clk) begin
    if (rst || st_r != T_AUTO_REMOVE || !quality_ok) begin
      good_cnt_r <= `LMSC_CNT_ZERO;
    end else if (!good_done) begin
      good_cnt_r <= good_cnt_r + `LMSC_CNT_ONE;
    end
  end

  // bad-quality counter, restarts on any good sample
  always_ff @(posedge core_clk) begin
    if (rst || st_r != T_AUTO_REMOVE || quality_ok) begin
      bad_cnt_r <= `LMSC_CNT_ZERO;
    end else if (!bad_done) begin
      bad_cnt_r <= bad_cnt_r + `LMSC_CNT_ONE;
    end
  end

  // ==========================================================
  // terminal state classes
  assign auto_st   = st_r == T_ACTIVE || st_r == T_AUTO_FAULT ||
                     st_r == T_AUTO_REMOVE || st_r == T_AUTO_TROUBLE_ANALYSIS;
  assign manual_st = st_r == T_MANUAL_FAULT || st_r == T_MANUAL_REMOVE ||
                     st_r == T_POWER_OFF || st_r == T_FORCED;
  assign pwr_evt   = fuse_alarm && auto_st;

  // ==========================================================
  // terminal next state; anything not listed is refused
  always_comb begin
    st_nxt = st_r;
    if (pwr_evt) begin
      st_nxt = T_AUTO_POWER_ALARM;
    end else if (manual_st) begin
      // manual states move among themselves; restoral via auto remove
      if (req_restore) begin
        st_nxt = T_AUTO_REMOVE;
      end else if (req_forced && st_r != T_FORCED) begin
        st_nxt = T_FORCED;
      end else if (req_power_off && st_r != T_POWER_OFF) begin
        st_nxt = T_POWER_OFF;
      end else if (req_manual_fault && st_r != T_MANUAL_FAULT) begin
        st_nxt = T_MANUAL_FAULT;
      end else if (req_remove && st_r != T_MANUAL_REMOVE) begin
        st_nxt = T_MANUAL_REMOVE;
      end
    end else begin
      case (st_r)
        T_ACTIVE: begin
          if (link_fail_single || link_fail_double) begin
            st_nxt = T_AUTO_REMOVE;
          end else if (auto_diag_req) begin
            st_nxt = T_AUTO_TROUBLE_ANALYSIS;
          end else if (req_remove) begin
            st_nxt = T_MANUAL_REMOVE;
          end
        end
        T_AUTO_REMOVE: begin
          if (auto_diag_req || bad_done) begin
            st_nxt = T_AUTO_TROUBLE_ANALYSIS;
          end else if (good_done) begin
            st_nxt = T_ACTIVE;
          end
        end
        T_AUTO_TROUBLE_ANALYSIS: begin
          if (diag_done) begin
            st_nxt = diag_pass ? T_AUTO_REMOVE : T_AUTO_FAULT;
          end
        end
        T_AUTO_FAULT: begin
          if (diag_done && man_diag_r && diag_pass) begin
            st_nxt = T_AUTO_REMOVE;
          end
        end
        T_AUTO_POWER_ALARM: begin
          if (req_restore) begin
            st_nxt = T_AUTO_REMOVE;
          end
        end
        default: st_nxt = st_r;
      endcase
    end
  end

  // ==========================================================
  // terminal state register and decoded outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r             <= T_ACTIVE;
      term_code_r      <= `LMSC_CODE_ACT;
      term_operating_r <= 1'b1;
      term_eligible_r  <= 1'b1;
      term_powered_r   <= 1'b1;
    end else begin
      st_r             <= st_nxt;
      term_code_r      <= code_of(st_nxt);
      term_operating_r <= st_nxt == T_ACTIVE || st_nxt == T_MANUAL_REMOVE;
      term_eligible_r  <= st_nxt == T_ACTIVE || st_nxt == T_MANUAL_REMOVE ||
                          st_nxt == T_MANUAL_FAULT;
      term_powered_r   <= st_nxt != T_POWER_OFF;
    end
  end

  // ==========================================================
  // recovery flavour: double failure selects the short window
  always_ff @(posedge core_clk) begin
    if (rst) begin
      emer_r <= 1'b0;
    end else if (st_r == T_ACTIVE && st_nxt == T_AUTO_REMOVE) begin
      emer_r <= link_fail_double;
    end else if (st_nxt != T_AUTO_REMOVE) begin
      emer_r <= 1'b0;
    end
  end

  // ==========================================================
  // diagnostic launch; a manual run is only honoured in auto fault
  always_ff @(posedge core_clk) begin
    if (rst) begin
      diag_start_r <= 1'b0;
      man_diag_r   <= 1'b0;
    end else begin
      diag_start_r <= 1'b0;
      if (st_nxt == T_AUTO_TROUBLE_ANALYSIS && st_r != T_AUTO_TROUBLE_ANALYSIS) begin
        diag_start_r <= 1'b1;
      end else if (st_r == T_AUTO_FAULT && st_nxt == T_AUTO_FAULT &&
                   manual_diag_req && !man_diag_r) begin
        diag_start_r <= 1'b1;
        man_diag_r   <= 1'b1;
      end else if (diag_done || st_r != T_AUTO_FAULT) begin
        man_diag_r   <= 1'b0;
      end
    end
  end

  // ==========================================================
  // status reports: power alarm wins over a query in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_report_r <= 1'b0;
      status_kind_r   <= `LMSC_RPT_TERM;
      status_code_r   <= `LMSC_CODE_ACT;
    end else begin
      status_report_r <= pwr_evt || terminal_status_query || link_status_query;
      if (pwr_evt || terminal_status_query) begin
        status_kind_r <= `LMSC_RPT_TERM;
        status_code_r <= code_of(st_nxt);
      end else if (link_status_query) begin
        status_kind_r <= `LMSC_RPT_LINK;
        status_code_r <= {lst[1], lst[0]};
      end
    end
  end

  // ==========================================================
  // both links; a command reaches only the selected one
  for (genvar i = 0; i < 2; i++) begin : g_link
    lmsc_link u_link (
      .core_clk     (core_clk),
      .rst          (rst),
      .cmd_release  (link_release_cmd  && link_sel == 1'(i)),
      .cmd_operate  (link_operate_cmd  && link_sel == 1'(i)),
      .cmd_ready    (link_ready_cmd    && link_sel == 1'(i)),
      .cmd_delay    (link_delay_cmd    && link_sel == 1'(i)),
      .cmd_activate (link_activate_cmd && link_sel == 1'(i)),
      .mate_active  (ltraf[1-i]),
      .state_r      (lst[i]),
      .connected_r  (lconn[i]),
      .traffic_r    (ltraf[i]),
      .access_op_r  (lop[i])
    );
  end

  // link status copied into output flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      voice_link_a_r    <= LINK_STANDBY_CONNECTED;
      voice_link_b_r    <= LINK_STANDBY_CONNECTED;
      link_connected_r  <= 2'h3;
      link_traffic_r    <= 2'h0;
      access_operated_r <= 2'h0;
    end else begin
      voice_link_a_r    <= lst[0];
      voice_link_b_r    <= lst[1];
      link_connected_r  <= lconn;
      link_traffic_r    <= ltraf;
      access_operated_r <= lop;
    end
  end

  // ==========================================================
  // standby loop test: loop first, then signal, then wait result
  // a request with no standby-connected link is ignored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lt_r                  <= LT_IDLE;
      sb_r                  <= `LMSC_LINK_A;
      loop_applied_r        <= 2'h0;
      tp_test_standby_out_r <= 1'b0;
      test_result_r         <= 1'b0;
      test_passed_r         <= 1'b0;
    end else begin
      tp_test_standby_out_r <= 1'b0;
      test_result_r         <= 1'b0;
      case (lt_r)
        LT_IDLE: begin
          if ((tp_test_standby_in || office_test_req) &&
              (lst[0] == LINK_STANDBY_CONNECTED ||
               lst[1] == LINK_STANDBY_CONNECTED)) begin
            sb_r <= lst[0] == LINK_STANDBY_CONNECTED ? `LMSC_LINK_A : `LMSC_LINK_B;
            lt_r <= LT_LOOP;
          end
        end
        LT_LOOP: begin
          loop_applied_r[sb_r] <= 1'b1;
          lt_r                 <= LT_SEND;
        end
        LT_SEND: begin
          tp_test_standby_out_r <= 1'b1;
          lt_r                  <= LT_WAIT;
        end
        LT_WAIT: begin
          if (tp_test_passed || tp_test_failed) begin
            test_result_r  <= 1'b1;
            test_passed_r  <= tp_test_passed;
            loop_applied_r <= 2'h0;
            lt_r           <= LT_IDLE;
          end
        end
        default: lt_r <= LT_IDLE;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_code_range: assert property (term_code_r >= `LMSC_CODE_ACT &&
    term_code_r <= `LMSC_CODE_FORC) else $error("terminal code out of range");
  a_fuse_alarm: assert property (fuse_alarm && auto_st |=>
    term_code_r == `LMSC_CODE_APWR && status_report_r)
    else $error("fuse alarm not taken to power alarm");
  a_link_failure: assert property (st_r == T_ACTIVE && !fuse_alarm &&
    (link_fail_single || link_fail_double) |=> term_code_r == `LMSC_CODE_AREM)
    else $error("link failure did not remove terminal");
  a_active_entry: assert property (term_code_r == `LMSC_CODE_ACT && !$past(rst) &&
    $past(term_code_r) != `LMSC_CODE_ACT |-> $past(term_code_r) == `LMSC_CODE_AREM)
    else $error("active entered other than from auto remove");
  a_trb_result: assert property (st_r == T_AUTO_TROUBLE_ANALYSIS &&
    diag_done && !fuse_alarm |=> term_code_r ==
    ($past(diag_pass) ? `LMSC_CODE_AREM : `LMSC_CODE_AFLT))
    else $error("diagnostic result misrouted");
  a_forced_hold: assert property (st_r == T_FORCED && !req_restore &&
    !req_remove && !req_manual_fault |=> term_code_r != `LMSC_CODE_ACT && !term_eligible_r)
    else $error("forced terminal left toward service");
  a_status_query: assert property (terminal_status_query && !pwr_evt |=>
    status_report_r && status_kind_r == `LMSC_RPT_TERM && status_code_r == term_code_r)
    else $error("status query not answered");
  a_one_active: assert property (!(ltraf[0] && ltraf[1]))
    else $error("both links active");
  a_loop_first: assert property ($rose(tp_test_standby_out_r) |->
    $past(loop_applied_r != 2'h0) && loop_applied_r != 2'h0)
    else $error("test signal sent before loop");
  a_far_request: assert property (lt_r == LT_IDLE && tp_test_standby_in &&
    (lst[0] == LINK_STANDBY_CONNECTED || lst[1] == LINK_STANDBY_CONNECTED)
    |-> ##3 tp_test_standby_out_r)
    else $error("far-end test request not answered");

  c_power_alarm: cover property (st_r == T_AUTO_POWER_ALARM);
  c_loop_test:   cover property (test_result_r && test_passed_r);
  c_recovered:   cover property (st_r == T_AUTO_REMOVE ##1 st_r == T_ACTIVE);
  c_manual_path: cover property (st_r == T_MANUAL_FAULT ##[1:20] st_r == T_AUTO_REMOVE);
endmodule
`default_nettype wire

// File: testbench/lmsc_tp_model.sv
// transfer point model answering standby link tests
`timescale 1ns/1ns
`default_nettype none
module lmsc_tp_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic go,
  input  wire logic pass,
  input  wire logic standby_sig,
  output logic      test_standby,
  output logic      passed,
  output logic      failed
);
  int wait_r;
  // ==========================================
  // request a test, answer some cycles after the loop is confirmed
  always_ff @(posedge core_clk) begin
    test_standby <= go && !rst;
    passed <= 1'b0;
    failed <= 1'b0;
    if (rst) begin
      wait_r <= 0;
    end else if (standby_sig) begin
      wait_r <= 4;
    end else if (wait_r > 1) begin
      wait_r <= wait_r - 1;
    end else if (wait_r == 1) begin
      wait_r <= 0;
      passed <= pass;
      failed <= !pass;
    end
  end
endmodule
`default_nettype wire

// File: testbench/lmsc_ctrl_test.sv
// self-checking bench for the link maintenance state controller
`timescale 1ns/1ns
`default_nettype none
module lmsc_ctrl_test;
  import lmsc_pkg::*;
  logic core_clk = 0, rst = 1, fail1 = 0, fail2 = 0, fuse = 0, q_ok = 1;
  logic adiag = 0, mdiag = 0, ddone = 0, dpass = 0, rrem = 0, rmf = 0;
  logic rpoff = 0, rforc = 0, rrest = 0, tq = 0, lq = 0, lsel = 0, seen;
  logic lrel = 0, lopr = 0, lrdy = 0, ldly = 0, lact = 0, otest = 0;
  logic go = 0, tpass = 1;
  wire logic tsin, tpp, tpf, oper, elig, pwr, dstart, srep, skind, tsout, tres, tpsd;
  wire logic [5:0] code, scode;
  lmsc_link_t la, lb;
  wire logic [1:0] conn, traf, acc, loopa;
  int err_count = 0, n_checks = 0, cyc = 0;
  // ==========================================
  // design with short recovery counts: 20, 5 and 40 cycles
  lmsc_ctrl #(.NORM_MON_CYC(20), .EMER_MON_CYC(5), .BAD_LIM_CYC(40)) u_dut (
    .core_clk(core_clk), .rst(rst), .link_fail_single(fail1), .link_fail_double(fail2),
    .fuse_alarm(fuse), .quality_ok(q_ok), .auto_diag_req(adiag), .manual_diag_req(mdiag),
    .diag_done(ddone), .diag_pass(dpass), .req_remove(rrem), .req_manual_fault(rmf),
    .req_power_off(rpoff), .req_forced(rforc), .req_restore(rrest),
    .terminal_status_query(tq), .link_status_query(lq), .link_sel(lsel),
    .link_release_cmd(lrel), .link_operate_cmd(lopr), .link_ready_cmd(lrdy),
    .link_delay_cmd(ldly), .link_activate_cmd(lact), .tp_test_standby_in(tsin),
    .tp_test_passed(tpp), .tp_test_failed(tpf), .office_test_req(otest),
    .term_code_r(code), .term_operating_r(oper), .term_eligible_r(elig),
    .term_powered_r(pwr), .diag_start_r(dstart), .status_report_r(srep),
    .status_kind_r(skind), .status_code_r(scode), .voice_link_a_r(la), .voice_link_b_r(lb),
    .link_connected_r(conn), .link_traffic_r(traf), .access_operated_r(acc),
    .loop_applied_r(loopa), .tp_test_standby_out_r(tsout), .test_result_r(tres),
    .test_passed_r(tpsd));
  lmsc_tp_model u_tp (.core_clk(core_clk), .rst(rst), .go(go), .pass(tpass),
    .standby_sig(tsout), .test_standby(tsin), .passed(tpp), .failed(tpf));
  // ==========================================
  // clock, hang guard and shared tasks
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      stop_test;
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask
  task automatic chk(logic [5:0] got, logic [5:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report(logic [5:0] c);
    seen = srep;
    tick(1);
    chk(seen | srep, 6'h01);
    chk(scode, c);
  endtask
  task automatic lcmd(logic sel, ref logic c);
    lsel = sel;
    pulse(c);
    tick(2); // state shows two edges after the command
  endtask
  task automatic stop_test;
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================
  // scenarios, one task each
  task automatic t_manual;
    pulse(rmf); chk(code, 6'h20);
    pulse(rrem); chk(code, 6'h26); chk({oper, elig}, 6'h3);
    pulse(tq); report(6'h26);
    pulse(rmf); chk(code, 6'h25); chk({oper, elig}, 6'h1);
    pulse(rpoff); chk(code, 6'h27); chk(elig, 6'h0);
    pulse(rforc); chk(code, 6'h28); chk({pwr, oper, elig}, 6'h4);
    tick(30); chk(code, 6'h28);
    pulse(rrest); chk(code, 6'h22);
    tick(12); chk(code, 6'h22);
    tick(15); chk(code, 6'h20);
  endtask
  task automatic t_auto;
    pulse(fail1); chk(code, 6'h22);
    q_ok = 0;
    tick(30); chk(code, 6'h22);
    for (int i = 0; i < 30 && code !== 6'h24; i++) tick(1);
    chk(code, 6'h24); chk(dstart, 6'h1);
    q_ok = 1;
    pulse(ddone); chk(code, 6'h21);
    pulse(mdiag); pulse(ddone); chk(code, 6'h21);
    pulse(mdiag); dpass = 1; pulse(ddone); chk(code, 6'h22);
    pulse(fuse); chk(code, 6'h23); report(6'h23);
    pulse(rrest); tick(25); chk(code, 6'h20);
    pulse(fail2); chk(code, 6'h22); tick(8); chk(code, 6'h20);
    pulse(adiag); chk(code, 6'h24); chk(dstart, 6'h1);
    pulse(ddone); chk(code, 6'h22); tick(25); chk(code, 6'h20);
  endtask
  task automatic t_links;
    lcmd(0, lact); chk(la, LINK_ACTIVE); chk(traf, 6'h1);
    lcmd(1, lact); chk(lb, LINK_STANDBY_CONNECTED); chk(traf, 6'h1);
    lcmd(1, lrel); chk(lb, LINK_UNAVAILABLE_RELEASED); chk(acc[1], 6'h0);
    lcmd(1, lopr); chk(lb, LINK_UNAVAILABLE_OPERATED); chk(acc[1], 6'h1);
    lcmd(1, lact); chk(lb, LINK_UNAVAILABLE_OPERATED);
    lcmd(1, lrdy); chk(lb, LINK_STANDBY_CONNECTED); chk(conn[1], 6'h1);
    lcmd(1, ldly); chk(lb, LINK_STANDBY_DELAYED); chk({conn[1], traf[1]}, 6'h0);
    lcmd(1, lrdy); pulse(lq); tick(1); chk(skind, 6'h1); chk(scode, 6'h08);
  endtask
  task automatic t_loop(logic office, logic pass);
    tpass = pass;
    if (office) pulse(otest);
    else pulse(go);
    for (int i = 0; i < 20 && tsout !== 1; i++) tick(1);
    chk({tsout, loopa}, 6'h6);
    for (int i = 0; i < 20 && tres !== 1; i++) tick(1);
    chk({tres, tpsd}, {1'b1, pass});
  endtask
  // ==========================================
  // main sequence
  initial begin
    tick(10);
    rst = 0;
    t_manual;
    t_auto;
    t_links;
    t_loop(0, 1);
    t_loop(1, 0);
    stop_test;
  end
endmodule
`default_nettype wire
